// *** dci_ctrl.sv ***
`timescale 1ns/10ps
module dci_ctrl #(
	parameter int POWERUP_CYC = dci_pkg::POWERUP_CYC,
	parameter int DIV = 1
) (
	dci_if.ctrl link,
	input wire logic clk,
	input wire logic rst_n,
	output logic init_done_reg
);
	// ************************************************************
	// Link clock divider: this end makes the clock
	// ************************************************************
	logic [7:0] div_reg;
	logic lclk_reg;
	logic lclk_n_reg;
	logic tick;
	// Commands launch with the falling link edge so they sit still at the rising one
	assign tick = div_reg == 8'(DIV - 1) && lclk_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 8'h00;
			lclk_reg <= 1'b0;
			lclk_n_reg <= 1'b1;
		end else if (div_reg == 8'(DIV - 1)) begin
			div_reg <= 8'h00;
			lclk_reg <= !lclk_reg;
			lclk_n_reg <= lclk_reg; // Complement from a flop, not a gate
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end
	assign link.link_clk = lclk_reg;
	assign link.clk_complement = lclk_n_reg;

	// ************************************************************
	// Init sequencer; issues on the edge before the link rises
	// ************************************************************
	typedef enum {S_PWR, S_CKE, S_PREA1, S_EMR2, S_EMR3, S_EMR1, S_MRDLL, S_PREA2,
		S_REF, S_MROP, S_DLLWAIT, S_OCDDEF, S_OCDEXIT, S_DONE} dci_state_t;
	dci_state_t state_reg;
	logic [17:0] wait_reg;
	logic [7:0] dll_cnt_reg;
	logic [1:0] ref_reg;

	// Each command followed by mode-set cycle time of nops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_PWR;
			wait_reg <= 18'h00000;
			ref_reg <= 2'h0;
			dll_cnt_reg <= 8'h00;
			init_done_reg <= 1'b0;
			link.cke <= 1'b0; // [R7]
			link.termination_ctrl <= 1'b0; // [R7]
			{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= dci_pkg::CMD_DESELECT;
			{link.bank_sel_hi, link.bank_sel_lo} <= 2'h0;
			link.addr <= 13'h0000;
			link.low_lane_mask <= 1'b0;
			link.high_lane_mask <= 1'b0;
			link.dq_wr <= 16'h0000;
		end else if (tick) begin
			{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= dci_pkg::CMD_NOP;
			if (dll_cnt_reg != 8'h00) begin
				dll_cnt_reg <= dll_cnt_reg - 8'h01; // [R24]
			end
			if (wait_reg != 18'h00000) begin
				wait_reg <= wait_reg - 18'h00001; // [R17]
			end else begin
				wait_reg <= 18'(dci_pkg::MRD_CLKS);
				case (state_reg)
					S_PWR: begin
						wait_reg <= 18'(POWERUP_CYC); // [R8]
						state_reg <= S_CKE;
					end
					S_CKE: begin
						link.cke <= 1'b1; // [R8]
						wait_reg <= 18'(dci_pkg::CKE_WAIT_CYC); // [R9]
						state_reg <= S_PREA1;
					end
					S_PREA1, S_PREA2: begin
						{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= dci_pkg::CMD_PRECHARGE;
						link.addr <= 13'h0001 << dci_pkg::AP_BIT; // [R9] [R12]
						state_reg <= state_reg == S_PREA1 ? S_EMR2 : S_REF;
					end
					S_EMR2, S_EMR3, S_EMR1, S_MRDLL, S_MROP, S_OCDDEF, S_OCDEXIT: begin
						{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= dci_pkg::CMD_MODE; // [R16]
						link.addr <= 13'h0000; // [R10]
						case (state_reg)
							S_EMR2: begin
								{link.bank_sel_hi, link.bank_sel_lo} <= dci_pkg::BANK_EMR2;
								state_reg <= S_EMR3;
							end
							S_EMR3: begin
								{link.bank_sel_hi, link.bank_sel_lo} <= dci_pkg::BANK_EMR3;
								state_reg <= S_EMR1;
							end
							S_EMR1: begin
								{link.bank_sel_hi, link.bank_sel_lo} <= dci_pkg::BANK_EMR1;
								state_reg <= S_MRDLL;
							end
							S_MRDLL: begin
								{link.bank_sel_hi, link.bank_sel_lo} <= dci_pkg::BANK_MR;
								link.addr <= dci_pkg::DEF_MODE | (13'h0001 << dci_pkg::DLLRST_BIT); // [R11]
								dll_cnt_reg <= 8'(dci_pkg::DLL_LOCK_CLKS); // [R14]
								state_reg <= S_PREA2;
							end
							S_MROP: begin
								{link.bank_sel_hi, link.bank_sel_lo} <= dci_pkg::BANK_MR;
								link.addr <= dci_pkg::DEF_MODE; // [R13] [R18] [R21] [R22]
								state_reg <= S_DLLWAIT;
							end
							S_OCDDEF: begin
								{link.bank_sel_hi, link.bank_sel_lo} <= dci_pkg::BANK_EMR1;
								link.addr[dci_pkg::OCD_LSB +: 3] <= dci_pkg::OCD_DEFAULT; // [R14]
								state_reg <= S_OCDEXIT;
							end
							default: begin
								{link.bank_sel_hi, link.bank_sel_lo} <= dci_pkg::BANK_EMR1;
								link.addr[dci_pkg::OCD_LSB +: 3] <= dci_pkg::OCD_EXIT; // [R14]
								state_reg <= S_DONE;
							end
						endcase
					end
					S_REF: begin
						{link.cs_n, link.ras_n, link.cas_n, link.we_n} <= dci_pkg::CMD_REFRESH;
						ref_reg <= ref_reg + 2'h1; // [R12]
						if (ref_reg == 2'(dci_pkg::REFRESH_COUNT - 1)) begin
							state_reg <= S_MROP;
						end
					end
					S_DLLWAIT: begin
						wait_reg <= 18'h00000;
						if (dll_cnt_reg == 8'h00) begin
							state_reg <= S_OCDDEF; // [R14] [R24]
						end
					end
					S_DONE: begin
						wait_reg <= 18'h00000;
						init_done_reg <= 1'b1;
					end
					default: state_reg <= S_PWR;
				endcase
			end
		end
	end
endmodule : dci_ctrl

// *** dci_if.sv ***
`timescale 1ns/10ps
interface dci_if;
	logic link_clk;
	logic clk_complement;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic bank_sel_lo;
	logic bank_sel_hi;
	logic [12:0] addr;
	logic termination_ctrl;
	logic low_lane_mask;
	logic high_lane_mask;
	logic [15:0] dq_wr;
	logic [15:0] dq_rd;
	logic dq_rd_valid;

	modport ctrl (
		output link_clk, clk_complement, cke, cs_n, ras_n, cas_n, we_n,
		output bank_sel_lo, bank_sel_hi, addr, termination_ctrl,
		output low_lane_mask, high_lane_mask, dq_wr,
		input dq_rd, dq_rd_valid
	);
	modport mem (
		input link_clk, clk_complement, cke, cs_n, ras_n, cas_n, we_n,
		input bank_sel_lo, bank_sel_hi, addr, termination_ctrl,
		input low_lane_mask, high_lane_mask, dq_wr,
		output dq_rd, dq_rd_valid
	);
endinterface : dci_if

// *** dci_mem.sv ***
`timescale 1ns/10ps
// Function
// R1: Decode activate/read/write/precharge/refresh/mode/nop/deselect
// R2: Clock-enable history picks refresh, self refresh, powerdown
// R3: Masked byte lanes are not written
// R4: Bursts of four or eight locations
// R5: Activate latches bank and row
// R6: Column from low bits, A10 means autoprecharge
// R7: Controller holds clock-enable, termination low
// R8: Controller waits powerup time then raises clock-enable
// R9: Nop for 400ns then precharge all
// R10: Program extended registers two, three, one
// R11: Mode register write with loop reset
// R12: Precharge all then two refreshes
// R13: Mode register write without loop reset
// R14: Driver default then calibration exit
// R15: Mode load when all strobes, banks low
// R16: Mode write only when precharged, clock-enable high
// R17: Wait mode-set cycle time after mode write
// R18: Mode register must be programmed first
// R19: Burst length and ordering from mode bits
// R20: Read latency from mode bits A6..A4
// R21: Controller picks smallest adequate read latency
// R22: Test and loop-reset bits zero normally
// R23: Extended one: loop enable, half driver
// R24: Wait 200 clocks before first read
module dci_mem #(
	parameter int COLS = 64
) (
	dci_if.mem link,
	input wire logic rst_n,
	output logic [12:0] operating_mode_reg,
	output logic dll_enabled_reg,
	output logic half_drive_reg,
	output logic self_refresh_reg,
	output logic power_down_reg,
	output logic [1:0] open_bank_reg,
	output logic [12:0] open_row_reg
);
	// ************************************************************
	// Decoding helpers
	// ************************************************************
	logic cke_prev_reg;
	logic row_open_reg;
	logic [3:0] cmd;
	logic [1:0] bank;
	logic [15:0] mem_array [0:COLS-1];

	assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
	assign bank = {link.bank_sel_hi, link.bank_sel_lo};

	function automatic logic is_idle_cmd(input logic [3:0] c);
		is_idle_cmd = c[3] || (c == dci_pkg::CMD_NOP); // [R2]
	endfunction : is_idle_cmd

	// Burst address for beat n; interleave xors, sequential wraps
	function automatic logic [9:0] burst_col(input logic [9:0] start, input logic [2:0] n,
		input logic bl8, input logic ilv);
		logic [2:0] low;
		low = ilv ? (start[2:0] ^ n) : (start[2:0] + n);
		burst_col = bl8 ? {start[9:3], low} : {start[9:2], low[1:0]};
	endfunction : burst_col

	// Clock-enable history, sampled every rising link edge
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			cke_prev_reg <= 1'b0;
		end else begin
			cke_prev_reg <= link.cke; // [R2]
		end
	end

	// ************************************************************
	// Mode and extended registers
	// ************************************************************
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			operating_mode_reg <= 13'h0000;
			dll_enabled_reg <= 1'b0;
			half_drive_reg <= 1'b0;
		end else if (cke_prev_reg && link.cke && cmd == dci_pkg::CMD_MODE) begin // [R1]
			if (bank == dci_pkg::BANK_MR) begin
				operating_mode_reg <= link.addr; // [R15]
			end else if (bank == dci_pkg::BANK_EMR1) begin
				dll_enabled_reg <= !link.addr[dci_pkg::DLL_DIS_BIT]; // [R23]
				half_drive_reg <= link.addr[dci_pkg::HALF_DRV_BIT]; // [R23]
			end
		end
	end

	// ************************************************************
	// Power states
	// ************************************************************
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			self_refresh_reg <= 1'b0;
			power_down_reg <= 1'b0;
		end else if (cke_prev_reg && !link.cke) begin
			if (cmd == dci_pkg::CMD_REFRESH) begin
				self_refresh_reg <= 1'b1; // [R2]
			end else if (is_idle_cmd(cmd)) begin
				power_down_reg <= 1'b1; // [R2]
			end
		end else if (!cke_prev_reg && link.cke && is_idle_cmd(cmd)) begin
			self_refresh_reg <= 1'b0; // [R2]
			power_down_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Row activation
	// ************************************************************
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			open_bank_reg <= 2'h0;
			open_row_reg <= 13'h0000;
		end else if (cke_prev_reg && link.cke && cmd == dci_pkg::CMD_ACTIVATE) begin
			open_bank_reg <= bank; // [R5]
			open_row_reg <= link.addr; // [R5]
		end
	end

	// ************************************************************
	// Burst engine; storage is 64 columns of one row only (model limit)
	// ************************************************************
	logic wr_active_reg;
	logic rd_active_reg;
	logic [2:0] beat_reg;
	logic [2:0] lat_reg;
	logic [9:0] start_col_reg;
	logic autopre_reg;
	logic bl8;
	logic ilv;
	logic [9:0] cur_col;
	logic [2:0] last_beat;
	logic burst_end;

	assign bl8 = operating_mode_reg[dci_pkg::BL_LSB +: 3] == dci_pkg::BL8_CODE; // [R19]
	assign ilv = operating_mode_reg[dci_pkg::BT_BIT]; // [R19]
	assign last_beat = bl8 ? 3'h7 : 3'h3; // [R4]
	assign cur_col = burst_col(start_col_reg, beat_reg, bl8, ilv);
	// Last beat of a write, or of a read whose latency has run out
	assign burst_end = (wr_active_reg || (rd_active_reg && lat_reg == 3'h0)) &&
		beat_reg == last_beat;

	// Open row tracking; only one row is modelled, so a precharge naming
	// its bank or all banks closes it
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			row_open_reg <= 1'b0;
		end else if (cke_prev_reg && link.cke && cmd == dci_pkg::CMD_ACTIVATE) begin
			row_open_reg <= 1'b1; // [R5]
		end else if (cke_prev_reg && link.cke && cmd == dci_pkg::CMD_PRECHARGE &&
			(link.addr[dci_pkg::AP_BIT] || bank == open_bank_reg)) begin
			row_open_reg <= 1'b0; // [R1]
		end else if (burst_end && autopre_reg) begin
			row_open_reg <= 1'b0; // [R6]
		end
	end

	// Command capture and beat counting
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_active_reg <= 1'b0;
			rd_active_reg <= 1'b0;
			beat_reg <= 3'h0;
			lat_reg <= 3'h0;
			start_col_reg <= 10'h000;
			autopre_reg <= 1'b0;
		end else if (cke_prev_reg && link.cke && row_open_reg &&
			(cmd == dci_pkg::CMD_READ || cmd == dci_pkg::CMD_WRITE)) begin
			start_col_reg <= link.addr[dci_pkg::COL_W-1:0]; // [R6]
			autopre_reg <= link.addr[dci_pkg::AP_BIT]; // [R6]
			wr_active_reg <= cmd == dci_pkg::CMD_WRITE;
			rd_active_reg <= cmd == dci_pkg::CMD_READ;
			beat_reg <= 3'h0;
			// Latency counts from the registered read; one edge spent here
			lat_reg <= operating_mode_reg[dci_pkg::CL_LSB +: 3] - 3'h1; // [R20]
		end else if (rd_active_reg && lat_reg != 3'h0) begin
			lat_reg <= lat_reg - 3'h1; // [R20]
		end else if (wr_active_reg || rd_active_reg) begin
			beat_reg <= beat_reg + 3'h1; // [R4]
			if (beat_reg == last_beat) begin
				wr_active_reg <= 1'b0;
				rd_active_reg <= 1'b0;
			end
		end
	end

	// Write storage with per-lane masking; one beat per rising link edge
	always_ff @(posedge link.link_clk) begin
		if (wr_active_reg) begin
			if (!link.low_lane_mask) begin
				mem_array[cur_col[5:0]][7:0] <= link.dq_wr[7:0]; // [R3]
			end
			if (!link.high_lane_mask) begin
				mem_array[cur_col[5:0]][15:8] <= link.dq_wr[15:8]; // [R3]
			end
		end
	end

	// Read return
	always_ff @(posedge link.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			link.dq_rd <= 16'h0000;
			link.dq_rd_valid <= 1'b0;
		end else begin
			link.dq_rd_valid <= rd_active_reg && lat_reg == 3'h0; // [R20]
			link.dq_rd <= mem_array[cur_col[5:0]];
		end
	end
endmodule : dci_mem

// *** dci_monitor.sv ***
`timescale 1ns/10ps
module dci_monitor (
	input wire logic link_clk,
	input wire logic rst_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic bank_sel_lo,
	input wire logic bank_sel_hi,
	input wire logic [12:0] addr,
	input wire logic termination_ctrl
);
	// ************************************************************
	// Command views on the wire
	// ************************************************************
	default clocking @(posedge link_clk); endclocking
	default disable iff (!rst_n);
	logic idle;
	logic mode;
	logic refr;
	logic mr_sel;
	// Deselect counts as idle whatever the strobes show
	assign idle = cs_n || {ras_n, cas_n, we_n} == 3'h7;
	assign mode = !cs_n && {ras_n, cas_n, we_n} == 3'h0;
	assign refr = !cs_n && {ras_n, cas_n, we_n} == 3'h1;
	assign mr_sel = mode && !bank_sel_lo && !bank_sel_hi;

	// ************************************************************
	// Controller duties
	// ************************************************************
	chk_odt_held_low: assert property (!cke |-> !termination_ctrl)
		else $error("termination driven while clock enable low");
	chk_cke_rise_idle: assert property ($rose(cke) |-> idle)
		else $error("clock enable raised with a real command");
	// 400 ns is five link cycles at 80 ns
	chk_cke_wait_idle: assert property ($rose(cke) |=> idle [*5])
		else $error("command too soon after clock enable");
	chk_mode_set_gap: assert property (mode |=> idle [*2])
		else $error("mode write not followed by two idle cycles");
	chk_mode_cke_high: assert property (mode |-> cke && $past(cke))
		else $error("mode write without clock enable history");
	chk_refresh_cke: assert property (refr |-> cke && $past(cke))
		else $error("auto refresh without clock enable history");
	chk_mr_normal_bits: assert property (mr_sel && !addr[8] |-> !addr[7])
		else $error("test mode bit set in normal mode write");
	chk_dll_on_write: assert property (mode && bank_sel_lo && !bank_sel_hi |-> !addr[0])
		else $error("loop disabled by extended write");
	cover property ($rose(cke));
	cover property (mode && addr[8]);
	cover property (refr ##[1:8] refr);
endmodule : dci_monitor

// *** dci_pkg.sv ***
package dci_pkg;
	// ************************************************************
	// Command encodings {cs_n, ras_n, cas_n, we_n}
	// ************************************************************
	localparam logic [3:0] CMD_ACTIVATE = 4'h3;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_MODE = 4'h0;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_DESELECT = 4'hF;

	// ************************************************************
	// Widths and field positions
	// ************************************************************
	localparam int ADDR_W = 13;
	localparam int DATA_W = 16;
	localparam int COL_W = 10;
	localparam int AP_BIT = 10;
	localparam int BL_LSB = 0;
	localparam int BT_BIT = 3;
	localparam int CL_LSB = 4;
	localparam int TM_BIT = 7;
	localparam int DLLRST_BIT = 8;
	localparam int DLL_DIS_BIT = 0;
	localparam int HALF_DRV_BIT = 1;
	localparam int OCD_LSB = 7;
	localparam logic [2:0] BL4_CODE = 3'h2;
	localparam logic [2:0] BL8_CODE = 3'h3;
	localparam logic [2:0] OCD_DEFAULT = 3'h7;
	localparam logic [2:0] OCD_EXIT = 3'h0;
	localparam logic [1:0] BANK_MR = 2'h0;
	localparam logic [1:0] BANK_EMR1 = 2'h1;
	localparam logic [1:0] BANK_EMR2 = 2'h2;
	localparam logic [1:0] BANK_EMR3 = 2'h3;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_NS = 40;
	localparam int POWERUP_US = 200;
	localparam int CKE_WAIT_NS = 400;
	localparam int DLL_LOCK_CLKS = 200;
	localparam int MRD_CLKS = 2;
	localparam int REFRESH_COUNT = 2;
	localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int CKE_WAIT_CYC = (CKE_WAIT_NS + CLK_NS - 1) / CLK_NS;

	// ************************************************************
	// Default operating mode programmed after init
	// ************************************************************
	localparam logic [2:0] DEF_CL = 3'h3;
	localparam logic [12:0] DEF_MODE = 13'h0032;
endpackage : dci_pkg

// *** ddr2_command_init_mode_bench.sv ***
`timescale 1ns/10ps
module ddr2_command_init_mode_bench;
	// ************************************************************
	// Clocks, links and design ends
	// ************************************************************
	logic clk;
	logic rst_n;
	logic init_done_reg;
	logic ke2;
	int n_errors;
	int total_checks;
	int cyc;
	int lcyc;
	int t_rst;
	int t_ocd;
	logic [9:0] seen[$];
	logic [12:0] mode_a;
	logic [12:0] mode_b;
	logic [12:0] row_b;
	logic [1:0] bank_b;
	logic dll_a;
	logic dll_b;
	logic half_b;
	logic sr_b;
	logic pd_b;
	dci_if lnk();
	dci_if lnk2();
	dci_ctrl #(.POWERUP_CYC(20), .DIV(1)) dci_ctrl_i (.link(lnk), .clk(clk), .rst_n(rst_n),
		.init_done_reg(init_done_reg));
	dci_mem dci_mem_i (.link(lnk), .rst_n(rst_n), .operating_mode_reg(mode_a),
		.dll_enabled_reg(dll_a), .half_drive_reg(), .self_refresh_reg(), .power_down_reg(),
		.open_bank_reg(), .open_row_reg());
	// Second memory end driven by the bench itself
	dci_mem dci_mem_x_i (.link(lnk2), .rst_n(rst_n), .operating_mode_reg(mode_b),
		.dll_enabled_reg(dll_b), .half_drive_reg(half_b), .self_refresh_reg(sr_b),
		.power_down_reg(pd_b), .open_bank_reg(bank_b), .open_row_reg(row_b));
	dci_monitor dci_monitor_i (.link_clk(lnk.link_clk), .rst_n(rst_n), .cke(lnk.cke),
		.cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n),
		.bank_sel_lo(lnk.bank_sel_lo), .bank_sel_hi(lnk.bank_sel_hi), .addr(lnk.addr),
		.termination_ctrl(lnk.termination_ctrl));
	assign lnk2.clk_complement = ~lnk2.link_clk;
	// Free-running clocks, link period unrelated to the system clock
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	initial begin
		lnk2.link_clk = 1'h0;
		#7;
		forever #24 lnk2.link_clk = ~lnk2.link_clk;
	end

	// ************************************************************
	// Helpers
	// ************************************************************
	// Compressed command record: strobes, bank, key address bits
	function automatic logic [9:0] code(logic [2:0] c, logic [1:0] b, logic [12:0] a);
		if (c != 3'h0) return {c, 2'h0, c == 3'h2 && a[10], 4'h0};
		if (b == 2'h0) return {5'h00, 2'h0, a[8], a[7], 1'h0};
		if (b == 2'h1) return {5'h01, 1'h0, a[9:7], a[0]};
		return {3'h0, b, 5'h00};
	endfunction : code
	always @(posedge lnk.link_clk) begin
		lcyc <= lcyc + 1;
		if (rst_n && lnk.cke && !lnk.cs_n && {lnk.ras_n, lnk.cas_n, lnk.we_n} != 3'h7) begin
			seen.push_back(code({lnk.ras_n, lnk.cas_n, lnk.we_n},
				{lnk.bank_sel_hi, lnk.bank_sel_lo}, lnk.addr));
			if (seen[$] == 10'h004) t_rst = lcyc;
			if (seen[$] == 10'h02E) t_ocd = lcyc;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic gap(input int n);
		repeat (n) @(posedge lnk2.link_clk);
	endtask : gap
	// Ends at the edge where the command is taken
	task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
		@(posedge lnk2.link_clk);
		lnk2.cke <= ke2;
		{lnk2.cs_n, lnk2.ras_n, lnk2.cas_n, lnk2.we_n} <= c;
		{lnk2.bank_sel_hi, lnk2.bank_sel_lo} <= b;
		lnk2.addr <= a;
		@(posedge lnk2.link_clk);
		{lnk2.cs_n, lnk2.ras_n, lnk2.cas_n, lnk2.we_n} <= dci_pkg::CMD_NOP;
	endtask : cmd
	task automatic wr(input logic [9:0] col, input int bl, input logic [15:0] base,
		input int mlo, input int mhi);
		cmd(dci_pkg::CMD_WRITE, 2'h2, {3'h0, col});
		for (int n = 0; n < bl; n++) begin
			lnk2.dq_wr <= base + 16'(n);
			lnk2.low_lane_mask <= (n == mlo);
			lnk2.high_lane_mask <= (n == mhi);
			@(posedge lnk2.link_clk);
		end
		lnk2.low_lane_mask <= 1'h0;
		lnk2.high_lane_mask <= 1'h0;
		lnk2.dq_wr <= ~lnk2.dq_wr;
		gap(3);
	endtask : wr
	// Strict window: valid only on edges cl .. cl+bl-1 after the read edge
	task automatic rd(input logic [9:0] col, input int bl, input int cl, input logic [15:0] e[8]);
		cmd(dci_pkg::CMD_READ, 2'h2, {3'h0, col});
		for (int k = 0; k < 16; k++) begin
			@(negedge lnk2.link_clk);
			chk({15'h0, lnk2.dq_rd_valid}, {15'h0, k >= cl && k < cl + bl});
			if (k >= cl && k < cl + bl) chk(lnk2.dq_rd, e[k - cl]);
		end
	endtask : rd

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic init_seq();
		logic [9:0] ex[11] = '{10'h110, 10'h040, 10'h060, 10'h020, 10'h004, 10'h110,
			10'h080, 10'h080, 10'h000, 10'h02E, 10'h020};
		int i;
		i = 0;
		while (init_done_reg !== 1'h1 && i < 5000) begin
			@(posedge clk);
			i++;
		end
		repeat (8) @(posedge lnk.link_clk);
		chk(16'(init_done_reg), 16'h0001);
		chk(16'(seen.size()), 16'h000B);
		for (i = 0; i < 11 && i < seen.size(); i++) chk(16'(seen[i]), 16'(ex[i]));
		chk(16'(t_ocd - t_rst >= dci_pkg::DLL_LOCK_CLKS), 16'h0001);
		chk(16'(mode_a), 16'(dci_pkg::DEF_MODE));
		chk(16'(dll_a), 16'h0001);
	endtask : init_seq
	task automatic bursts();
		ke2 = 1'h1;
		cmd(dci_pkg::CMD_NOP, 2'h0, 13'h0000);
		gap(6);
		cmd(dci_pkg::CMD_MODE, 2'h1, 13'h0003);
		gap(2);
		chk({14'h0, dll_b, half_b}, 16'h0001);
		cmd(dci_pkg::CMD_MODE, 2'h1, 13'h0000);
		gap(dci_pkg::MRD_CLKS - 1);
		cmd(dci_pkg::CMD_MODE, 2'h0, 13'h014B);
		gap(2);
		chk({14'h0, dll_b, half_b}, 16'h0002);
		chk(16'(mode_b), 16'h014B);
		gap(200);
		cmd(dci_pkg::CMD_ACTIVATE, 2'h2, 13'h1ABC);
		gap(2);
		chk({1'h0, bank_b, row_b}, 16'h5ABC);
		wr(10'h001, 8, 16'h1100, -1, -1);
		wr(10'h000, 8, 16'hA050, 2, 5);
		rd(10'h000, 8, 4, '{16'hA050, 16'hA051, 16'hA003, 16'hA053,
			16'hA054, 16'h1155, 16'hA056, 16'hA057});
		rd(10'h005, 8, 4, '{16'h1155, 16'hA054, 16'hA057, 16'hA056,
			16'hA051, 16'hA050, 16'hA053, 16'hA003});
		cmd(dci_pkg::CMD_PRECHARGE, 2'h0, 13'h0400);
		cmd(dci_pkg::CMD_MODE, 2'h0, 13'h0032);
		gap(dci_pkg::MRD_CLKS - 1);
		cmd(dci_pkg::CMD_ACTIVATE, 2'h2, 13'h1ABC);
		gap(2);
		rd(10'h006, 4, 3, '{16'hA056, 16'hA057, 16'hA054, 16'h1155, 16'h0, 16'h0, 16'h0, 16'h0});
		// Read with autoprecharge closes the row; the next read finds none open
		cmd(dci_pkg::CMD_READ, 2'h2, 13'h0406);
		gap(8);
		rd(10'h006, 0, 3, '{default: 16'h0000});
	endtask : bursts
	task automatic power_states();
		ke2 = 1'h0;
		cmd(dci_pkg::CMD_NOP, 2'h0, 13'h0000);
		gap(2);
		chk(16'(pd_b), 16'h0001);
		cmd(dci_pkg::CMD_ACTIVATE, 2'h1, 13'h0555);
		ke2 = 1'h1;
		cmd(dci_pkg::CMD_DESELECT, 2'h0, 13'h0000);
		gap(2);
		chk({pd_b, bank_b, row_b}, 16'h5ABC);
		cmd(dci_pkg::CMD_PRECHARGE, 2'h0, 13'h0400);
		ke2 = 1'h0;
		cmd(dci_pkg::CMD_REFRESH, 2'h0, 13'h0000);
		gap(2);
		chk(16'(sr_b), 16'h0001);
		ke2 = 1'h1;
		cmd(dci_pkg::CMD_NOP, 2'h0, 13'h0000);
		gap(2);
		chk(16'(sr_b), 16'h0000);
	endtask : power_states

	// ************************************************************
	// Run control
	// ************************************************************
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// Whole run needs about 530 system cycles; far above that means a hang
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		rst_n = 1'h0;
		ke2 = 1'h0;
		lnk2.cke = 1'h0;
		{lnk2.cs_n, lnk2.ras_n, lnk2.cas_n, lnk2.we_n} = dci_pkg::CMD_DESELECT;
		{lnk2.bank_sel_hi, lnk2.bank_sel_lo} = 2'h0;
		lnk2.addr = 13'h0000;
		lnk2.termination_ctrl = 1'h0;
		lnk2.low_lane_mask = 1'h0;
		lnk2.high_lane_mask = 1'h0;
		lnk2.dq_wr = 16'h0000;
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		fork
			init_seq();
			begin
				bursts();
				power_states();
			end
		join
		end_of_test();
	end
endmodule : ddr2_command_init_mode_bench
